// ---- common/charger_cfg_defs.vh ----
// constants for the battery-short and termination configuration block
// How it works
// - short_timeout_sel in bits 7:5 picks 1,2,4,10,30,60,120 or 180 s, reset code 100 (30 s).
// - short_threshold_sel in bits 2:0 picks 2.0 V to 2.7 V in 0.1 V steps, reset code 100.
// - term_current_code in bits 7:5 maps to 12.5 through 170.0 mA, reset code 010.
// - the divide-by-twenty bit 4 makes termination one twentieth of charge current, above all.
// - the divide-by-ten bit 3, with bit 4 clear, gives one tenth and beats bit 2 and the code.
// - the divide-by-five bit 2, with bits 4 and 3 clear, gives one fifth and beats the code.
// - any fractional termination current is clamped to 12.5 mA .. 170 mA.
// - sysen_policy 00 raises system enable when the regulator runs and system voltage exists.
// - sysen_policy 01 raises system enable from the battery-side node, in charging mode.
// - sysen_policy 10 raises system enable and opens the isolation switch below weak level.
// - sysen_policy 11 enables in regulator mode with charging off, else only at or above weak.
// - policy 10 acts only with input supply at 0 V and battery_monitor_enable set.
// - a detected battery short sets short_fault_flag, bit 3 of the fault register.
// - writing one to the fault flag, or cycling input supply, clears it.
`ifndef CHARGER_CFG_DEFS_VH
`define CHARGER_CFG_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADDR_FAULT 8'h0D
`define ADDR_SHORT_CFG 8'h10
`define ADDR_TERM_CFG 8'h11

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define TIMEOUT_MSB 7
`define TIMEOUT_LSB 5
`define THRESH_MSB 2
`define THRESH_LSB 0
`define TERM_MSB 7
`define TERM_LSB 5
`define DIV20_BIT 4
`define DIV10_BIT 3
`define DIV5_BIT 2
`define POLICY_MSB 1
`define POLICY_LSB 0
`define FAULT_SHORT_BIT 3
`define SHORT_CFG_RESET 8'h84
`define TERM_CFG_RESET 8'h40

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_HZ 20000000
`define MS_CYCLES (`CLK_HZ / 1000)

// ----------------------------------------
// current units: tenths of a milliamp
// ----------------------------------------
`define TERM_MIN 16'h007D
`define TERM_MAX 16'h06A4

`endif

// ---- rtl/short_detector.v ----
// battery-short timer: counts milliseconds below the threshold
`timescale 1ns/1ps
`include "charger_cfg_defs.vh"
module short_detector #(
   parameter MS_CYCLES = `MS_CYCLES
) (
   input wire clk_in,
   input wire rst_n_in,
   input wire below_in,
   input wire [2:0] timeout_sel_in,
   output reg short_pulse_out
);
   reg [15:0] tick_reg;
   reg [17:0] ms_reg;
   reg [17:0] limit;

   always @* begin
      case (timeout_sel_in)
         3'h0: limit = 18'h003E8;
         3'h1: limit = 18'h007D0;
         3'h2: limit = 18'h00FA0;
         3'h3: limit = 18'h02710;
         3'h4: limit = 18'h07530;
         3'h5: limit = 18'h0EA60;
         3'h6: limit = 18'h1D4C0;
         default: limit = 18'h2BF20;
      endcase
   end

   // restarts whenever voltage recovers; fires once per continuous short
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tick_reg <= 16'h0000;
         ms_reg <= 18'h00000;
         short_pulse_out <= 1'b0;
      end else begin
         short_pulse_out <= 1'b0;
         if (!below_in) begin
            tick_reg <= 16'h0000;
            ms_reg <= 18'h00000;
         end else if (ms_reg < limit) begin
            if (tick_reg == MS_CYCLES[15:0] - 16'h0001) begin
               tick_reg <= 16'h0000;
               ms_reg <= ms_reg + 18'h00001;
               short_pulse_out <= (ms_reg + 18'h00001 == limit);
            end else begin
               tick_reg <= tick_reg + 16'h0001;
            end
         end
      end
   end
endmodule

// ---- rtl/term_current_calc.v ----
// termination current selection and clamping
`timescale 1ns/1ps
`include "charger_cfg_defs.vh"
module term_current_calc (
   input wire [7:0] term_cfg_in,
   input wire [15:0] charge_ma_x10_in,
   output reg [15:0] term_ma_x10_out
);
   function [15:0] clamp;
      input [15:0] v;
      begin
         if (v < `TERM_MIN) clamp = `TERM_MIN;
         else if (v > `TERM_MAX) clamp = `TERM_MAX;
         else clamp = v;
      end
   endfunction

   always @* begin
      if (term_cfg_in[`DIV20_BIT]) begin
         term_ma_x10_out = clamp(charge_ma_x10_in / 16'h0014);
      end else if (term_cfg_in[`DIV10_BIT]) begin
         term_ma_x10_out = clamp(charge_ma_x10_in / 16'h000A);
      end else if (term_cfg_in[`DIV5_BIT]) begin
         term_ma_x10_out = clamp(charge_ma_x10_in / 16'h0005);
      end else begin
         case (term_cfg_in[`TERM_MSB:`TERM_LSB])
            3'h0: term_ma_x10_out = 16'h007D;
            3'h1: term_ma_x10_out = 16'h0145;
            3'h2: term_ma_x10_out = 16'h020D;
            3'h3: term_ma_x10_out = 16'h02D5;
            3'h4: term_ma_x10_out = 16'h039D;
            3'h5: term_ma_x10_out = 16'h0497;
            3'h6: term_ma_x10_out = 16'h0591;
            default: term_ma_x10_out = 16'h06A4;
         endcase
      end
   end
endmodule

// ---- rtl/charger_short_and_termination_cfg.v ----
// register bank for battery-short, termination and system-enable configuration
`timescale 1ns/1ps
`include "charger_cfg_defs.vh"
module charger_short_and_termination_cfg #(
   parameter MS_CYCLES = `MS_CYCLES
) (
   input wire core_clk_in,
   input wire arst_n_in,
   input wire reg_wr_in,
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   output reg [7:0] reg_rdata_out,
   input wire [15:0] charge_current_ma_x10_in,
   input wire [2:0] battery_mv_code_in,
   input wire battery_below_short_in,
   input wire regulator_active_in,
   input wire system_voltage_ok_in,
   input wire battery_side_node_ok_in,
   input wire battery_side_node_weak_in,
   input wire charging_enabled_in,
   input wire input_supply_present_in,
   input wire battery_monitor_enable_in,
   output reg [15:0] term_current_ma_x10_out,
   output reg [2:0] short_threshold_sel_out,
   output reg system_enable_out,
   output reg isolation_off_out,
   output reg short_fault_flag_out
);
   // ----------------------------------------
   // reset release and pin synchronisers
   // ----------------------------------------
   reg [1:0] rst_sync_reg;
   wire rst_n = rst_sync_reg[1];

   always @(posedge core_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) rst_sync_reg <= 2'b00;
      else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end

   // bit order: below, reg, sysv, node_ok, weak, chg, vin, bmon
   wire [7:0] pins_raw = {battery_below_short_in, regulator_active_in, system_voltage_ok_in,
                          battery_side_node_ok_in, battery_side_node_weak_in,
                          charging_enabled_in, input_supply_present_in,
                          battery_monitor_enable_in};
   reg [7:0] s1_reg;
   reg [7:0] s2_reg;
   reg [7:0] s3_reg;
   reg [7:0] pins_reg;

   // a change is accepted only when the second and third stages agree
   always @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= 8'h00;
         s2_reg <= 8'h00;
         s3_reg <= 8'h00;
         pins_reg <= 8'h00;
      end else begin
         s1_reg <= pins_raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         pins_reg <= (pins_reg & (s2_reg ^ s3_reg)) | (s2_reg & s3_reg);
      end
   end

   wire below_s = pins_reg[7];
   wire reg_act_s = pins_reg[6];
   wire sysv_s = pins_reg[5];
   wire node_ok_s = pins_reg[4];
   wire weak_s = pins_reg[3];
   wire chg_en_s = pins_reg[2];
   wire vin_s = pins_reg[1];
   wire bmon_s = pins_reg[0];

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   reg [7:0] short_cfg_reg;
   reg [7:0] term_cfg_reg;
   reg vin_prev_reg;
   wire short_pulse;

   always @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         short_cfg_reg <= `SHORT_CFG_RESET;
         term_cfg_reg <= `TERM_CFG_RESET;
      end else if (reg_wr_in) begin
         if (reg_addr_in == `ADDR_SHORT_CFG)
            short_cfg_reg <= reg_wdata_in & 8'hE7;
         if (reg_addr_in == `ADDR_TERM_CFG)
            term_cfg_reg <= reg_wdata_in;
      end
   end

   // ----------------------------------------
   // short fault flag
   // ----------------------------------------
   // set wins over a same-cycle write-one clear so no event is lost
   always @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         short_fault_flag_out <= 1'b0;
         vin_prev_reg <= 1'b0;
      end else begin
         vin_prev_reg <= vin_s;
         if (short_pulse)
            short_fault_flag_out <= 1'b1;
         else if (reg_wr_in && reg_addr_in == `ADDR_FAULT &&
                  reg_wdata_in[`FAULT_SHORT_BIT])
            short_fault_flag_out <= 1'b0;
         else if (vin_s && !vin_prev_reg)
            short_fault_flag_out <= 1'b0;
      end
   end

   short_detector #(.MS_CYCLES(MS_CYCLES)) u_short (
      .clk_in(core_clk_in),
      .rst_n_in(rst_n),
      .below_in(below_s),
      .timeout_sel_in(short_cfg_reg[`TIMEOUT_MSB:`TIMEOUT_LSB]),
      .short_pulse_out(short_pulse)
   );

   wire [15:0] term_calc;

   term_current_calc u_term (
      .term_cfg_in(term_cfg_reg),
      .charge_ma_x10_in(charge_current_ma_x10_in),
      .term_ma_x10_out(term_calc)
   );

   // ----------------------------------------
   // system enable policy
   // ----------------------------------------
   wire [1:0] policy = term_cfg_reg[`POLICY_MSB:`POLICY_LSB];
   reg sysen_next;
   reg iso_off_next;

   always @* begin
      sysen_next = 1'b0;
      iso_off_next = 1'b0;
      case (policy)
         2'b00: sysen_next = reg_act_s & sysv_s;
         2'b01: sysen_next = node_ok_s & chg_en_s;
         2'b10: begin
            if (!vin_s && bmon_s) begin
               sysen_next = 1'b1;
               iso_off_next = weak_s;
            end
         end
         default: sysen_next = chg_en_s ? !weak_s : reg_act_s;
      endcase
   end

   // ----------------------------------------
   // registered outputs and read-back
   // ----------------------------------------
   always @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         system_enable_out <= 1'b0;
         isolation_off_out <= 1'b0;
         term_current_ma_x10_out <= 16'h020D;
         short_threshold_sel_out <= 3'h4;
         reg_rdata_out <= 8'h00;
      end else begin
         system_enable_out <= sysen_next;
         isolation_off_out <= iso_off_next;
         term_current_ma_x10_out <= term_calc;
         short_threshold_sel_out <= short_cfg_reg[`THRESH_MSB:`THRESH_LSB];
         case (reg_addr_in)
            `ADDR_SHORT_CFG: reg_rdata_out <= short_cfg_reg;
            `ADDR_TERM_CFG: reg_rdata_out <= term_cfg_reg;
            `ADDR_FAULT: reg_rdata_out <= {4'h0, short_fault_flag_out, 3'h0};
            default: reg_rdata_out <= 8'h00;
         endcase
      end
   end
endmodule

// ---- tb/cfg_props.sv ----
// checker on the ports of the configuration block
`timescale 1ns/1ps
module cfg_props (
   input wire core_clk_in,
   input wire arst_n_in,
   input wire reg_wr_in,
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire [7:0] reg_rdata_out,
   input wire battery_below_short_in,
   input wire regulator_active_in,
   input wire system_voltage_ok_in,
   input wire battery_side_node_ok_in,
   input wire battery_side_node_weak_in,
   input wire charging_enabled_in,
   input wire input_supply_present_in,
   input wire [15:0] term_current_ma_x10_out,
   input wire [2:0] short_threshold_sel_out,
   input wire system_enable_out,
   input wire isolation_off_out,
   input wire short_fault_flag_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!arst_n_in);
   // shadow of the policy field, so policy checks need no internal probes
   reg [1:0] pol_reg;
   always @(posedge core_clk_in or negedge arst_n_in)
      if (!arst_n_in) pol_reg <= 2'b00;
      else if (reg_wr_in && reg_addr_in == 8'h11) pol_reg <= reg_wdata_in[1:0];
   sequence s_quiet_clear;
      !battery_below_short_in [*8] ##0 (reg_wr_in && reg_addr_in == 8'h0D && reg_wdata_in[3]);
   endsequence
   a_thresh_mirror: assert property (reg_wr_in && reg_addr_in == 8'h10 |-> ##2
      short_threshold_sel_out == $past(reg_wdata_in[2:0], 2)) else $error("threshold copy");
   a_unused_bits_zero: assert property (reg_addr_in == 8'h10 |=>
      reg_rdata_out[4:3] == 2'b00) else $error("unused bits read back");
   a_term_in_range: assert property (term_current_ma_x10_out >= 16'h007D &&
      term_current_ma_x10_out <= 16'h06A4) else $error("termination out of range");
   a_iso_only_p10: assert property (isolation_off_out |-> pol_reg == 2'b10 ||
      $past(pol_reg) == 2'b10) else $error("isolation opened outside policy 10");
   a_sysen_p00: assert property ((pol_reg == 2'b00 && regulator_active_in &&
      system_voltage_ok_in) [*8] |-> system_enable_out) else $error("policy 00 enable");
   a_sysen_p01: assert property ((pol_reg == 2'b01 && battery_side_node_ok_in &&
      charging_enabled_in) [*8] |-> system_enable_out) else $error("policy 01 enable");
   a_sysen_p11: assert property ((pol_reg == 2'b11 && charging_enabled_in &&
      battery_side_node_weak_in) [*8] |-> !system_enable_out) else $error("policy 11 weak");
   a_p10_gated: assert property ((pol_reg == 2'b10 && input_supply_present_in) [*8]
      |-> !system_enable_out && !isolation_off_out) else $error("policy 10 with supply");
   a_fault_clear: assert property (s_quiet_clear |=> !short_fault_flag_out)
      else $error("fault flag not cleared");
   a_flag_cause: assert property ($rose(short_fault_flag_out) |->
      $past(battery_below_short_in, 8)) else $error("flag without low battery");
endmodule

// ---- tb/host_bus_model.sv ----
// host side model: strobed register writes and reads
`timescale 1ns/1ps
module host_bus_model (
   input wire clk_in,
   input wire [7:0] rdata_in,
   output reg wr_out,
   output reg [7:0] addr_out,
   output reg [7:0] wdata_out
);
   initial begin
      wr_out = 1'b0;
      addr_out = 8'h00;
      wdata_out = 8'h00;
   end
   task wr(input [7:0] a, input [7:0] v);
      begin
         @(negedge clk_in);
         wr_out = 1'b1;
         addr_out = a;
         wdata_out = v;
         @(negedge clk_in);
         wr_out = 1'b0;
         // stale data would hide a late sample
         wdata_out = ~v;
      end
   endtask
   task rd(input [7:0] a, output [7:0] v);
      begin
         @(negedge clk_in);
         addr_out = a;
         @(negedge clk_in);
         v = rdata_in;
      end
   endtask
endmodule

// ---- tb/tb_top.sv ----
// top testbench for the charger configuration block
`timescale 1ns/1ps
module tb_top;
   reg core_clk_in = 1'b0;
   reg arst_n_in = 1'b0;
   reg [15:0] charge = 16'h0000;
   reg below = 1'b0;
   reg [6:0] pins = 7'h00;
   reg [7:0] d;
   wire wr;
   wire [7:0] addr;
   wire [7:0] wdata;
   wire [7:0] rdata;
   wire [15:0] term;
   wire [2:0] thresh;
   wire sysen;
   wire iso;
   wire flag;
   integer bad_count = 0;
   integer checks = 0;
   integer n;
   integer cyc = 0;
   localparam [127:0] TBL = {16'h06A4, 16'h0591, 16'h0497, 16'h039D,
      16'h02D5, 16'h020D, 16'h0145, 16'h007D};
   initial forever #25 core_clk_in = ~core_clk_in;
   host_bus_model host_bus_model_inst (.clk_in(core_clk_in), .rdata_in(rdata), .wr_out(wr),
      .addr_out(addr), .wdata_out(wdata));
   charger_short_and_termination_cfg #(.MS_CYCLES(2)) charger_short_and_termination_cfg_inst (
      .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .reg_wr_in(wr), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata), .charge_current_ma_x10_in(charge),
      .battery_mv_code_in(3'h0), .battery_below_short_in(below),
      .regulator_active_in(pins[6]), .system_voltage_ok_in(pins[5]),
      .battery_side_node_ok_in(pins[4]), .battery_side_node_weak_in(pins[3]),
      .charging_enabled_in(pins[2]), .input_supply_present_in(pins[1]),
      .battery_monitor_enable_in(pins[0]), .term_current_ma_x10_out(term),
      .short_threshold_sel_out(thresh), .system_enable_out(sysen),
      .isolation_off_out(iso), .short_fault_flag_out(flag));
   task end_sim;
      begin
         if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   task chk(input [15:0] got, input [15:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("BAD %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task tc(input [7:0] cfg, input [15:0] ch, input [15:0] exp);
      begin
         charge = ch;
         host_bus_model_inst.wr(8'h11, cfg);
         repeat (3) @(negedge core_clk_in);
         chk(term, exp);
      end
   endtask
   // pins: regulator, sysv, node ok, weak, charging, supply, monitor
   task pc(input [7:0] cfg, input [6:0] p, input [1:0] exp, input [1:0] m);
      begin
         pins = p;
         host_bus_model_inst.wr(8'h11, cfg);
         repeat (8) @(negedge core_clk_in);
         chk({sysen, iso} & m, exp & m);
      end
   endtask
   task t_reset;
      begin
         host_bus_model_inst.rd(8'h10, d);
         chk(d, 16'h0084);
         host_bus_model_inst.rd(8'h11, d);
         chk(d, 16'h0040);
         host_bus_model_inst.rd(8'h20, d);
         chk(d, 16'h0000);
         chk(thresh, 16'h0004);
         chk(term, 16'h020D);
      end
   endtask
   task t_codes;
      begin
         for (n = 0; n < 8; n = n + 1) begin
            host_bus_model_inst.wr(8'h10, {n[2:0], 2'b11, n[2:0]});
            host_bus_model_inst.rd(8'h10, d);
            chk(d, {n[2:0], 2'b00, n[2:0]});
            chk(thresh, n[2:0]);
            tc({n[2:0], 5'h00}, 16'h1388, TBL[n*16 +: 16]);
         end
      end
   endtask
   task t_fraction;
      begin
         tc(8'hFC, 16'h1388, 16'h00FA);
         tc(8'hEC, 16'h1388, 16'h01F4);
         tc(8'hE4, 16'h1388, 16'h03E8);
         tc(8'h10, 16'h03E8, 16'h007D);
         tc(8'h04, 16'h9C40, 16'h06A4);
      end
   endtask
   task t_policy;
      begin
         pc(8'h00, 7'b1100000, 2'b10, 2'b11);
         pc(8'h00, 7'b1000000, 2'b00, 2'b10);
         pc(8'h01, 7'b0010100, 2'b10, 2'b10);
         pc(8'h01, 7'b0010000, 2'b00, 2'b10);
         pc(8'h02, 7'b0001001, 2'b01, 2'b01);
         pc(8'h02, 7'b0000001, 2'b00, 2'b01);
         pc(8'h02, 7'b0001011, 2'b00, 2'b11);
         pc(8'h02, 7'b0001000, 2'b00, 2'b11);
         pc(8'h03, 7'b1000000, 2'b10, 2'b11);
         pc(8'h03, 7'b0001100, 2'b00, 2'b11);
         pc(8'h03, 7'b0000100, 2'b10, 2'b11);
      end
   endtask
   task t_short;
      begin
         // 1 s at 2 cycles per ms is 2000 cycles
         host_bus_model_inst.wr(8'h10, 8'h04);
         below = 1'b1;
         repeat (1500) @(negedge core_clk_in);
         chk(flag, 16'h0000);
         below = 1'b0;
         repeat (10) @(negedge core_clk_in);
         below = 1'b1;
         n = 0;
         while (flag !== 1'b1 && n < 3000) begin
            @(negedge core_clk_in);
            n = n + 1;
         end
         chk(n >= 1995 && n <= 2015, 16'h0001);
         host_bus_model_inst.rd(8'h0D, d);
         chk(d, 16'h0008);
         below = 1'b0;
         repeat (10) @(negedge core_clk_in);
         host_bus_model_inst.wr(8'h0D, 8'h08);
         host_bus_model_inst.rd(8'h0D, d);
         chk(d, 16'h0000);
         // second short, cleared by a rising input supply instead of a write
         below = 1'b1;
         n = 0;
         while (flag !== 1'b1 && n < 3000) begin
            @(negedge core_clk_in);
            n = n + 1;
         end
         chk(flag, 16'h0001);
         pins[1] = 1'b1;
         repeat (8) @(negedge core_clk_in);
         chk(flag, 16'h0000);
         below = 1'b0;
         pins[1] = 1'b0;
      end
   endtask
   // ----------------------------------------
   // main sequence and hang guard
   // ----------------------------------------
   always @(posedge core_clk_in) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         bad_count = bad_count + 1;
         end_sim;
      end
   end
   initial begin
      repeat (4) @(negedge core_clk_in);
      arst_n_in = 1'b1;
      repeat (3) @(negedge core_clk_in);
      t_reset;
      t_codes;
      t_fraction;
      t_policy;
      t_short;
      end_sim;
   end
endmodule
bind charger_short_and_termination_cfg cfg_props cfg_props_inst (
   .core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .reg_wr_in(reg_wr_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
   .battery_below_short_in(battery_below_short_in), .regulator_active_in(regulator_active_in),
   .system_voltage_ok_in(system_voltage_ok_in), .battery_side_node_ok_in(battery_side_node_ok_in),
   .battery_side_node_weak_in(battery_side_node_weak_in),
   .charging_enabled_in(charging_enabled_in), .input_supply_present_in(input_supply_present_in),
   .term_current_ma_x10_out(term_current_ma_x10_out),
   .short_threshold_sel_out(short_threshold_sel_out), .system_enable_out(system_enable_out),
   .isolation_off_out(isolation_off_out), .short_fault_flag_out(short_fault_flag_out));
